// ---- logic/rtc_core_pkg.sv ----
// constants, field positions and carrier types of the real-time clock core
package rtc_core_pkg;

	// ********************************************
	// divider chain
	// ********************************************
	localparam int DIV_STAGES = 15;
	localparam int TICK_HZ = 32768;
	localparam logic [14:0] DIV_ZERO = 15'h0000;
	localparam logic [14:0] DIV_ONE = 15'h0001;
	// the seconds tick lands when the last stage rises, half a second after activation
	localparam logic [14:0] UPD_POS = 15'h4000;
	localparam int UPD_BIT = 14;
	localparam logic [2:0] DV_NORMAL = 3'b010;
	localparam logic [1:0] DV_RESET_HI = 2'b11;
	localparam logic [1:0] DV_OSC_OFF_HI = 2'b00;
	localparam logic [3:0] RS_NONE = 4'h0;
	localparam logic [3:0] RS_ONE = 4'h1;

	// ********************************************
	// timing, in 32.768 KHz ticks
	// ********************************************
	localparam int UIP_LEAD_US = 244;
	localparam int UIP_TICKS_INT = (UIP_LEAD_US * TICK_HZ + 999999) / 1000000;
	localparam logic [14:0] UIP_TICKS = 15'(UIP_TICKS_INT);
	localparam int ALARM_DELAY_NS = 30500;
	localparam int ALARM_TICKS = (ALARM_DELAY_NS * 32 + 999999) / 1000000;

	// ********************************************
	// timing control field positions
	// ********************************************
	localparam int DV_HI = 6;
	localparam int DV_LO = 4;
	localparam int RS_HI = 3;
	localparam int RS_LO = 0;

	// ********************************************
	// mode control bit positions
	// ********************************************
	localparam int MODE_FREEZE = 7;
	localparam int MODE_PIE = 6;
	localparam int MODE_AIE = 5;
	localparam int MODE_UIE = 4;
	localparam int MODE_DM = 2;
	localparam int MODE_24H = 1;

	// ********************************************
	// calendar constants
	// ********************************************
	localparam logic [7:0] MAX_SEC = 8'h3b;
	localparam logic [7:0] MAX_HR24 = 8'h17;
	localparam logic [7:0] HR12_NOON = 8'h0c;
	localparam logic [7:0] HR12_LAST = 8'h0b;
	localparam logic [7:0] MONTHS = 8'h0c;
	localparam logic [7:0] FEB = 8'h02;
	localparam logic [7:0] DAYS_31 = 8'h1f;
	localparam logic [7:0] DAYS_30 = 8'h1e;
	localparam logic [7:0] DAYS_29 = 8'h1d;
	localparam logic [7:0] DAYS_28 = 8'h1c;
	localparam logic [7:0] MAX_YEAR = 8'h63;
	localparam logic [7:0] TEN = 8'h0a;
	localparam logic [7:0] ONE = 8'h01;
	localparam logic [7:0] ZERO = 8'h00;
	localparam logic [1:0] DONT_CARE = 2'b11;
	localparam int HR_PM = 7;

	// ********************************************
	// flag byte positions
	// ********************************************
	localparam int FLAG_SUM = 7;
	localparam int FLAG_PF = 6;
	localparam int FLAG_AF = 5;
	localparam int FLAG_UF = 4;

	// time and calendar carrier
	typedef struct packed {
		logic [7:0] year;
		logic [7:0] month;
		logic [7:0] date;
		logic [7:0] hour;
		logic [7:0] min;
		logic [7:0] sec;
	} rtc_time_t;

	// alarm settings carrier
	typedef struct packed {
		logic [7:0] date;
		logic [7:0] month;
		logic [7:0] hour;
		logic [7:0] min;
		logic [7:0] sec;
	} rtc_alarm_t;

	localparam rtc_time_t TIME_RST = '{year: 8'h00, month: 8'h01, date: 8'h01,
		hour: 8'h00, min: 8'h00, sec: 8'h00};

endpackage : rtc_core_pkg

// ---- logic/rtc_timekeeping_alarm_core.sv ----
// real-time clock core: divider chain, calendar, freeze shadow, flags and alarm
//
// Functional notes
// - seconds tick comes from fifteen divide-by-two stages of the 32.768 KHz tick
// - divider control field picks counting, chain held in reset, or oscillator keep-alive
// - pattern 010 starts counting; first seconds update 500 ms later
// - rate select field picks one of fifteen chain taps for the periodic flag
// - periodic flag first rises half a selected period after activation
// - data mode bit selects BCD or binary time encoding
// - mode bit 1 selects 12-hour or 24-hour hours
// - February has 29 days every fourth year, year 2000 included
// - live counters advance every second even while frozen
// - setting freeze copies live time to shadow; host then sees only shadow
// - clearing freeze loads shadow into live counters at once, replacing a same-cycle update
// - update-ended flag set at the end of each update
// - update-ended enable gates that flag onto the interrupt request
// - update-in-progress goes high 244 us before each update
// - periodic enable gates the periodic flag onto the interrupt request
// - after each update, matching alarm fields set the alarm flag
// - alarm flag also drives the wake-up control output regardless of enable
// - alarm enable gates alarm matches onto the interrupt request
// - alarm byte with top bits 11 always matches
// - reading flags or reset clears all flags and the request
// - a repeat event while its flag is set is lost
// - alarm flag rises one 32.768 KHz tick after the update
module rtc_timekeeping_alarm_core
	import rtc_core_pkg::*;
(
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// 32.768 KHz timekeeping tick, one-cycle enable
	input wire logic i_osc_tick,
	// control registers
	input wire logic [6:0] i_timing_ctrl,
	input wire logic [7:0] i_mode_ctrl,
	input wire rtc_alarm_t i_alarm,
	// host time access
	input wire logic i_time_wr,
	input wire rtc_time_t i_time_wdata,
	output rtc_time_t o_time,
	// status and flags
	input wire logic i_flag_rd,
	output logic [7:0] o_flags,
	output logic o_uip,
	output logic o_osc_keep,
	// interrupt and wake-up
	output logic o_irq,
	output logic o_alarm_wake
);

	// ********************************************
	// reset release
	// ********************************************
	logic rst_meta_r;
	logic rst_n_r;

	// two-stage release of the asynchronous reset
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r <= rst_meta_r;
		end
	end

	// ********************************************
	// format helpers
	// ********************************************
	function automatic logic [7:0] to_bin(input logic [7:0] v, input logic bcd);
		return bcd ? ({4'h0, v[7:4]} * TEN + {4'h0, v[3:0]}) : v;
	endfunction : to_bin

	function automatic logic [7:0] from_bin(input logic [7:0] v, input logic bcd);
		return bcd ? {4'(v / TEN), 4'(v % TEN)} : v;
	endfunction : from_bin

	function automatic logic field_match(input logic [7:0] al, input logic [7:0] t);
		return (al[7:6] == DONT_CARE) || (al == t);
	endfunction : field_match

	function automatic logic [7:0] month_days(input logic [7:0] m, input logic [7:0] y);
		logic [7:0] d;
		d = DAYS_31;
		if (m == FEB) begin
			d = (y[1:0] == 2'b00) ? DAYS_29 : DAYS_28;
		end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h0b) begin
			d = DAYS_30;
		end
		return d;
	endfunction : month_days

	// ********************************************
	// control decode
	// ********************************************
	wire logic [2:0] dv = i_timing_ctrl[DV_HI:DV_LO];
	wire logic [3:0] rs = i_timing_ctrl[RS_HI:RS_LO];
	wire logic freeze = i_mode_ctrl[MODE_FREEZE];
	wire logic bcd = ~i_mode_ctrl[MODE_DM];
	wire logic hr24 = i_mode_ctrl[MODE_24H];
	wire logic run = (dv == DV_NORMAL);
	wire logic chain_rst = (dv[2:1] == DV_RESET_HI);

	// ********************************************
	// divider chain
	// ********************************************
	logic [14:0] div_r;
	wire logic [14:0] div_nxt = 15'(div_r + DIV_ONE);
	wire logic [3:0] tap = 4'(rs - RS_ONE);
	// update on the last stage's rise
	wire logic upd = i_osc_tick && run && div_nxt[UPD_BIT] && !div_r[UPD_BIT];
	// periodic event on the selected tap's rise
	wire logic per_evt = i_osc_tick && run && (rs != RS_NONE) && div_nxt[tap] && !div_r[tap];

	// chain counts from zero so the first update is half a second out
	always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			div_r <= DIV_ZERO;
		end else if (chain_rst) begin
			div_r <= DIV_ZERO;
		end else if (i_osc_tick && run) begin
			div_r <= div_nxt;
		end
	end

	// update-in-progress window ahead of the update
	assign o_uip = run && (div_r >= UPD_POS - UIP_TICKS) && (div_r < UPD_POS);
	// oscillator stays alive on battery unless the field reads 00x
	assign o_osc_keep = (dv[2:1] != DV_OSC_OFF_HI);

	// ********************************************
	// calendar increment
	// ********************************************
	rtc_time_t live_r;
	rtc_time_t shadow_r;
	rtc_time_t inc_time;

	always_comb begin
		logic [7:0] s;
		logic [7:0] m;
		logic [7:0] h;
		logic [7:0] d;
		logic [7:0] mo;
		logic [7:0] y;
		logic pm;
		logic carry;
		s = to_bin(live_r.sec, bcd);
		m = to_bin(live_r.min, bcd);
		d = to_bin(live_r.date, bcd);
		mo = to_bin(live_r.month, bcd);
		y = to_bin(live_r.year, bcd);
		pm = live_r.hour[HR_PM];
		carry = 1'b0;
		h = ZERO;
		inc_time = live_r;
		s = (s == MAX_SEC) ? ZERO : 8'(s + ONE);
		inc_time.sec = from_bin(s, bcd);
		if (s == ZERO) begin
			m = (m == MAX_SEC) ? ZERO : 8'(m + ONE);
			inc_time.min = from_bin(m, bcd);
		end
		if (s == ZERO && m == ZERO) begin
			if (hr24) begin
				h = to_bin(live_r.hour, bcd);
				carry = (h == MAX_HR24);
				h = carry ? ZERO : 8'(h + ONE);
				inc_time.hour = from_bin(h, bcd);
			end else begin
				h = to_bin({1'b0, live_r.hour[6:0]}, bcd);
				carry = (h == HR12_LAST) && pm;
				if (h == HR12_LAST) begin
					pm = ~pm;
				end
				h = (h == HR12_NOON) ? ONE : 8'(h + ONE);
				inc_time.hour = {pm, 7'(from_bin(h, bcd))};
			end
		end
		if (carry) begin
			if (d >= month_days(mo, y)) begin
				d = ONE;
				mo = (mo >= MONTHS) ? ONE : 8'(mo + ONE);
				if (mo == ONE) begin
					y = (y == MAX_YEAR) ? ZERO : 8'(y + ONE);
				end
			end else begin
				d = 8'(d + ONE);
			end
			inc_time.date = from_bin(d, bcd);
			inc_time.month = from_bin(mo, bcd);
			inc_time.year = from_bin(y, bcd);
		end
	end

	// ********************************************
	// live counters and shadow copy
	// ********************************************
	logic freeze_q_r;
	wire logic freeze_rise = freeze && !freeze_q_r;
	wire logic freeze_fall = !freeze && freeze_q_r;

	always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			freeze_q_r <= 1'b0;
		end else begin
			freeze_q_r <= freeze;
		end
	end

	// live counters; a shadow load or direct write replaces that cycle's update
	always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			live_r <= TIME_RST;
		// shadow loaded back on freeze release
		end else if (freeze_fall) begin
			live_r <= shadow_r;
		end else if (i_time_wr && !freeze) begin
			live_r <= i_time_wdata;
		end else if (upd) begin
			live_r <= inc_time;
		end
	end

	// snapshot on freeze, host writes land in shadow while frozen
	always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			shadow_r <= TIME_RST;
		end else if (freeze_rise) begin
			shadow_r <= live_r;
		end else if (i_time_wr && freeze) begin
			shadow_r <= i_time_wdata;
		end
	end

	assign o_time = freeze ? shadow_r : live_r;

	// ********************************************
	// alarm check and flags
	// ********************************************
	logic alarm_wait_r;
	logic pf_r;
	logic af_r;
	logic uf_r;
	// match examined one tick after the update
	wire logic alarm_chk = alarm_wait_r && i_osc_tick;
	// all five fields compared, don't-care bytes always match
	wire logic alarm_hit = alarm_chk
		&& field_match(i_alarm.sec, live_r.sec)
		&& field_match(i_alarm.min, live_r.min)
		&& field_match(i_alarm.hour, live_r.hour)
		&& field_match(i_alarm.date, live_r.date)
		&& field_match(i_alarm.month, live_r.month);

	always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			alarm_wait_r <= 1'b0;
		end else if (upd) begin
			alarm_wait_r <= 1'b1;
		end else if (alarm_chk) begin
			alarm_wait_r <= 1'b0;
		end
	end

	// read clears, set wins over the clear, repeats merge
	always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pf_r <= 1'b0;
			af_r <= 1'b0;
			uf_r <= 1'b0;
		end else begin
			// periodic flag set on tap rise
			pf_r <= (pf_r && !i_flag_rd) || per_evt;
			af_r <= (af_r && !i_flag_rd) || alarm_hit;
			uf_r <= (uf_r && !i_flag_rd) || upd;
		end
	end

	wire logic summary = (pf_r && i_mode_ctrl[MODE_PIE]) || (af_r && i_mode_ctrl[MODE_AIE])
		|| (uf_r && i_mode_ctrl[MODE_UIE]);

	// flag byte as the host reads it
	always_comb begin
		o_flags = ZERO;
		o_flags[FLAG_SUM] = summary;
		o_flags[FLAG_PF] = pf_r;
		o_flags[FLAG_AF] = af_r;
		o_flags[FLAG_UF] = uf_r;
	end

	assign o_irq = summary;
	assign o_alarm_wake = af_r;

endmodule : rtc_timekeeping_alarm_core

// ---- verif/osc_tick_model.sv ----
// timekeeping tick source standing in for the crystal oscillator
module osc_tick_model (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// tick toward the core
	output logic o_tick
);
	timeunit 1ns;
	timeprecision 1ps;
	// every second cycle carries a tick, far faster than real to keep runs short
	// held low while reset is applied
	always @(negedge i_sys_clk) begin
		o_tick <= i_rst_n ? ~o_tick : 1'b0;
	end
endmodule : osc_tick_model

// ---- verif/rtc_core_monitor.sv ----
// port assertions for the real-time clock core
module rtc_core_monitor
	import rtc_core_pkg::*;
(
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// controls
	input wire logic i_osc_tick,
	input wire logic [6:0] i_timing_ctrl,
	input wire logic [7:0] i_mode_ctrl,
	input wire logic i_flag_rd,
	// status
	input wire logic [7:0] o_flags,
	input wire logic o_uip,
	input wire logic o_osc_keep,
	input wire logic o_irq,
	input wire logic o_alarm_wake
);
	timeunit 1ns;
	timeprecision 1ps;
	// ************************
	// assertions
	// ************************
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);
	// enables lined up with the pending flags
	wire logic [2:0] en = {i_mode_ctrl[MODE_PIE], i_mode_ctrl[MODE_AIE], i_mode_ctrl[MODE_UIE]};
	// update-in-progress lasts at least eight clock cycles
	sequence uip_run;
		o_uip [*8];
	endsequence
	irq_summary_a: assert property (o_irq == o_flags[FLAG_SUM])
		else $error("irq differs from summary flag");
	summary_def_a: assert property (o_flags[FLAG_SUM] == |(o_flags[6:4] & en))
		else $error("summary flag wrong");
	read_clear_a: assert property (i_flag_rd && !i_osc_tick |=> o_flags[6:4] == 3'b000)
		else $error("flags not cleared by read");
	flags_hold_a: assert property (!i_flag_rd |=>
		(o_flags[6:4] & $past(o_flags[6:4])) == $past(o_flags[6:4]))
		else $error("flag dropped without read");
	alarm_wake_a: assert property (o_alarm_wake == o_flags[FLAG_AF])
		else $error("wake output differs from alarm flag");
	osc_keep_a: assert property (o_osc_keep == (i_timing_ctrl[DV_HI -: 2] != DV_OSC_OFF_HI))
		else $error("oscillator keep decode wrong");
	uip_lead_a: assert property ($rose(o_uip) |-> uip_run)
		else $error("update in progress too short");
	uf_after_uip_a: assert property ($rose(o_flags[FLAG_UF]) |-> $past(o_uip))
		else $error("update ended without busy before it");
	flags_tick_a: assert property ($rose(|o_flags[6:4]) |-> $past(i_osc_tick))
		else $error("flag set away from a tick");
endmodule : rtc_core_monitor

bind rtc_timekeeping_alarm_core rtc_core_monitor u_mon (.i_sys_clk(i_sys_clk),
	.i_rst_n(i_rst_n), .i_osc_tick(i_osc_tick), .i_timing_ctrl(i_timing_ctrl),
	.i_mode_ctrl(i_mode_ctrl), .i_flag_rd(i_flag_rd), .o_flags(o_flags), .o_uip(o_uip),
	.o_osc_keep(o_osc_keep), .o_irq(o_irq), .o_alarm_wake(o_alarm_wake));

// ---- verif/rtc_timekeeping_alarm_core_tb.sv ----
// self-checking bench for the real-time clock core
module rtc_timekeeping_alarm_core_tb
	import rtc_core_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, wr, rd;
	wire logic tick, irq, uip, keep, wake;
	logic [6:0] timing;
	logic [7:0] mode, flags, fseen;
	rtc_alarm_t alarm;
	rtc_time_t wdata, tm;
	int mismatches = 0;
	int checks_done = 0;
	int cycles = 0;
	int n;
	int u;
	// ************************
	// design and partner
	// ************************
	rtc_timekeeping_alarm_core dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_osc_tick(tick),
		.i_timing_ctrl(timing), .i_mode_ctrl(mode), .i_alarm(alarm), .i_time_wr(wr),
		.i_time_wdata(wdata), .o_time(tm), .i_flag_rd(rd), .o_flags(flags), .o_uip(uip),
		.o_osc_keep(keep), .o_irq(irq), .o_alarm_wake(wake));
	osc_tick_model osc (.i_sys_clk(clk), .i_rst_n(rst_n), .o_tick(tick));
	// ************************
	// tasks
	// ************************
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : report_and_stop
	task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask : cyc
	task automatic put_time(input rtc_time_t t);
		@(negedge clk);
		wr = 1'b1;
		wdata = t;
		@(negedge clk);
		wr = 1'b0;
	endtask : put_time
	task automatic read_flags();
		@(negedge clk);
		fseen = flags;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
	endtask : read_flags
	// hold the divider, clear flags, then start counting from zero
	task automatic restart(input logic [3:0] rs);
		timing = {3'b110, rs};
		cyc(2);
		read_flags();
		check("flags cleared", flags, 8'h00);
		check("irq cleared", irq, 1'b0);
		timing = {DV_NORMAL, rs};
	endtask : restart
	// count ticks until a flag bit is seen set, and the ticks spent busy
	task automatic wait_flag(input int b);
		n = 0;
		u = 0;
		while (flags[b] !== 1'b1 && cycles < 80000) begin
			@(negedge clk);
			if (tick) n++;
			if (tick && uip === 1'b1) u++;
		end
	endtask : wait_flag
	// ************************
	// clock, ceiling, tests
	// ************************
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// cut a hang short
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 80000) begin
			mismatches++;
			report_and_stop();
		end
	end
	initial begin
		rst_n = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		timing = 7'h00;
		mode = 8'h00;
		alarm = '0;
		wdata = '0;
		cyc(2);
		rst_n = 1'b1;
		cyc(3);
		check("reset time", tm, TIME_RST);
		check("reset flags", flags, 8'h00);
		check("keep off", keep, 1'b0);
		$display("test reset done");
		// periodic enable, the first four taps
		mode = 8'h40;
		for (int rs = 1; rs < 5; rs++) begin
			restart(4'(rs));
			wait_flag(FLAG_PF);
			check("pf ticks", n, 1 << (rs - 1));
			check("pf irq", irq, 1'b1);
		end
		check("keep on", keep, 1'b1);
		$display("test periodic done");
		// freeze, 24-hour BCD, alarm enable; host reinitialises after format change
		alarm = rtc_alarm_t'(40'hc0_c0_00_00_00);
		mode = 8'ha2;
		cyc(1);
		put_time(rtc_time_t'(48'h00_02_28_23_59_59));
		check("shadow", tm, 48'h00_02_28_23_59_59);
		// released well within a second
		mode = 8'h22;
		cyc(2);
		check("loaded", tm, 48'h00_02_28_23_59_59);
		restart(4'h0);
		wait_flag(FLAG_UF);
		check("first update", n, 16384);
		check("busy ticks", u, UIP_TICKS_INT);
		check("leap day", tm, 48'h00_02_29_00_00_00);
		check("alarm later", flags[FLAG_AF], 1'b0);
		cyc(4);
		check("alarm flag", flags[FLAG_AF], 1'b1);
		check("wake", wake, 1'b1);
		check("alarm irq", irq, 1'b1);
		mode = 8'ha2;
		cyc(2);
		check("snapshot", tm, 48'h00_02_29_00_00_00);
		$display("test calendar done");
		// 12-hour binary with update-ended enable; this also releases the freeze
		mode = 8'h14;
		put_time(rtc_time_t'(48'h63_0c_1f_8b_3b_3b));
		restart(4'h0);
		wait_flag(FLAG_UF);
		check("new year", tm, 48'h00_01_01_0c_00_00);
		check("busy ticks 12h", u, UIP_TICKS_INT);
		check("uf irq", irq, 1'b1);
		cyc(4);
		check("no alarm", flags[FLAG_AF], 1'b0);
		read_flags();
		check("flags read", fseen, 8'h90);
		check("irq after read", irq, 1'b0);
		$display("test twelve hour done");
		report_and_stop();
	end
endmodule : rtc_timekeeping_alarm_core_tb
